// ---- design/sgs_cfg.svh ----
/*
  Constants of the setting group selector: register offsets, field
  positions, reset values and event bit positions.
  Assumes inclusion by bare name from the package, the encoder, the top module and the bench.
*/
// Summary of operation
// - up to eight groups, exactly one active
// - reset: only group one enabled, selector idle
// - several groups enabled: control inputs drive activation
// - force on: ignore control inputs, forced, remote and local requests select
// - control inputs may be pulses or levels
// - simultaneous control inputs: lowest group number wins
// - two held levels: higher priority stays active
// - pulse-selected group stays latched until another request
// - force released: levels take over at once
// - forced field none or 1-8, acts as pulse
// - force resets off, gates remote and local
// - used groups count one to eight, reset one
// - remote request blocked by higher held level
// - status reports active group, reset group one
// - group eight level never blocks other requests
// - request for disabled group rejected, failure raised
`ifndef SGS_CFG_SVH
`define SGS_CFG_SVH

`define SGS_MAX_GROUPS    8
`define SGS_OFF_CTRL      8'h00
`define SGS_OFF_FORCE     8'h04
`define SGS_OFF_REMOTE    8'h08
`define SGS_OFF_STATUS    8'h0C
`define SGS_OFF_IRQ_STAT  8'h10
`define SGS_OFF_IRQ_MASK  8'h14
`define SGS_CTRL_FORCE    0
`define SGS_CTRL_USED_LSB 4
`define SGS_CTRL_USED_MSB 6
`define SGS_SEL_NONE      4'h0
`define SGS_SEL_MAX       4'h8
`define SGS_RST_USED      3'h0
`define SGS_RST_ACTIVE    3'h0
`define SGS_EV_CHANGE     0
`define SGS_EV_NOT_CFG    1
`define SGS_EV_FORCE_FAIL 2
`define SGS_EV_PRIO_FAIL  3

`endif

// ---- design/sgs_pkg.sv ----
/*
  Types shared by the setting group selector modules.
  Assumes sgs_cfg.svh sits on the include path.
*/
`include "sgs_cfg.svh"

package sgs_pkg;
  typedef logic [2:0] sgs_idx_t;
  typedef logic [3:0] sgs_sel_t;
  typedef logic [3:0] sgs_irq_t;
  typedef logic [`SGS_MAX_GROUPS-1:0] sgs_vec_t;
endpackage

// ---- design/sgs_prio_if.sv ----
/*
  Carrier between the selector top and its priority encoder.
  Assumes sgs_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

interface sgs_prio_if;
  sgs_pkg::sgs_vec_t req;
  logic              hit;
  sgs_pkg::sgs_idx_t idx;
  modport arb (input req, output hit, output idx);
  modport user (output req, input hit, input idx);
endinterface

`default_nettype wire

// ---- design/sgs_prio.sv ----
/*
  Fixed priority encoder: bit 0 (group one) highest, top bit lowest.
  Assumes a purely combinational use inside the selector.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgs_cfg.svh"

module sgs_prio (
  sgs_prio_if.arb pa
);
  always_comb begin
    pa.hit = 1'b0;
    pa.idx = '0;
    // scan from the lowest priority up so the highest one is kept
    for (int i = `SGS_MAX_GROUPS - 1; i >= 0; i--) begin
      if (pa.req[i]) begin
        pa.hit = 1'b1;
        pa.idx = 3'(i);
      end
    end
  end
endmodule

`default_nettype wire

// ---- design/sgs_top.sv ----
/*
  Setting group selector with an AHB-Lite register slave, sticky event
  status with mask and a level interrupt.
  Assumes group_ctrl and local panel inputs synchronous to clk, single
  word transfers from one master, zero wait states answered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgs_cfg.svh"

module sgs_top #(
  parameter int GROUPS = `SGS_MAX_GROUPS
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [7:0]  group_ctrl,
  input  wire logic        local_change_valid,
  input  wire logic [3:0]  local_change_group,
  output logic      [2:0]  active_group,
  output logic             irq,
  output logic             request_fail,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  localparam logic [2:0] MAX_IDX = 3'(GROUPS - 1);

  if (GROUPS < 2 || GROUPS > `SGS_MAX_GROUPS) begin : g_chk
    $error("sgs_top: GROUPS must lie in 2..8");
  end

  function automatic sgs_pkg::sgs_vec_t sgs_en_mask(input logic [2:0] cnt);
    sgs_pkg::sgs_vec_t m;
    for (int i = 0; i < `SGS_MAX_GROUPS; i++) begin
      m[i] = (3'(i) <= cnt) && (i < GROUPS);
    end
    return m;
  endfunction

  function automatic sgs_pkg::sgs_vec_t sgs_above(input sgs_pkg::sgs_idx_t g);
    sgs_pkg::sgs_vec_t m;
    for (int i = 0; i < `SGS_MAX_GROUPS; i++) begin
      m[i] = 3'(i) < g;
    end
    return m;
  endfunction

  function automatic logic sgs_sel_ok(input sgs_pkg::sgs_sel_t s);
    return (s != `SGS_SEL_NONE) && (s <= `SGS_SEL_MAX);
  endfunction

  // register state
  logic               force_enable;
  logic [2:0]         used_count;
  sgs_pkg::sgs_sel_t  forced_group_select;
  sgs_pkg::sgs_sel_t  remote_sel;
  sgs_pkg::sgs_irq_t  irq_status;
  sgs_pkg::sgs_irq_t  irq_mask;
  logic               ap_valid;
  logic               ap_write;
  logic [7:0]         ap_addr;

  logic               next_force_enable;
  logic [2:0]         next_used_count;
  sgs_pkg::sgs_sel_t  next_forced_group_select;
  sgs_pkg::sgs_sel_t  next_remote_sel;
  sgs_pkg::sgs_irq_t  next_irq_status;
  sgs_pkg::sgs_irq_t  next_irq_mask;
  logic               next_ap_valid;
  logic               next_ap_write;
  logic [7:0]         next_ap_addr;
  logic [31:0]        next_hrdata;
  logic               next_irq;

  // selection state
  sgs_pkg::sgs_idx_t  next_active;
  logic               next_request_fail;
  logic               fail_cfg;
  logic               fail_force;
  logic               fail_prio;

  // decoded data phase writes
  logic               wr;
  logic               wr_ctrl;
  logic               wr_force;
  logic               wr_remote;
  logic               wr_mask;
  logic               ap_take;
  sgs_pkg::sgs_sel_t  wsel;

  // one-shot group requests from force, panel and remote
  logic               fwr;
  logic               lwr;
  logic               rwr;
  logic               ext_req;
  logic               ext_remote;
  sgs_pkg::sgs_idx_t  ext_grp;
  sgs_pkg::sgs_vec_t  en;

  sgs_prio_if pif ();

  sgs_prio u_prio (
    .pa (pif.arb)
  );

  assign en        = sgs_en_mask(used_count);
  assign ap_take   = hsel && hready && htrans[1];
  assign wr        = ap_valid && ap_write;
  assign wsel      = hwdata[3:0];
  assign wr_ctrl   = wr && (ap_addr == `SGS_OFF_CTRL);
  assign wr_force  = wr && (ap_addr == `SGS_OFF_FORCE);
  assign wr_remote = wr && (ap_addr == `SGS_OFF_REMOTE);
  assign wr_mask   = wr && (ap_addr == `SGS_OFF_IRQ_MASK);
  assign fwr       = wr_force && sgs_sel_ok(wsel);
  assign lwr       = local_change_valid && sgs_sel_ok(local_change_group);
  assign rwr       = wr_remote && sgs_sel_ok(wsel);
  assign ext_req   = fwr || lwr || rwr;
  assign ext_remote = rwr && !fwr && !lwr;
  assign ext_grp   = lwr && !fwr ? 3'(local_change_group - 4'h1) : 3'(wsel - 4'h1);
  // disabled groups never reach the encoder
  assign pif.req   = group_ctrl & en;

  // group selection
  always_comb begin
    next_active = active_group;
    fail_cfg    = 1'b0;
    fail_force  = 1'b0;
    fail_prio   = 1'b0;
    if (!en[active_group]) begin
      next_active = `SGS_RST_ACTIVE;
    end
    if (force_enable) begin
      // control inputs do not select while forcing
      if (ext_req) begin
        if (!en[ext_grp]) begin
          fail_cfg = 1'b1;
        end else if (ext_remote && |(group_ctrl & sgs_above(ext_grp))) begin
          fail_prio = 1'b1;
        end else begin
          next_active = ext_grp;
        end
      end
    end else begin
      if (ext_req) begin
        fail_force = 1'b1;
      end
      if (|(group_ctrl & ~en)) begin
        fail_cfg = 1'b1;
      end
      // idle while one group; held levels and pulses both win by priority
      if (used_count != `SGS_RST_USED && pif.hit) begin
        next_active = pif.idx;
      end
    end
    next_request_fail = fail_cfg || fail_force || fail_prio;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      active_group <= `SGS_RST_ACTIVE;
      request_fail <= 1'b0;
    end else begin
      active_group <= next_active;
      request_fail <= next_request_fail;
    end
  end

  // bus and registers
  always_comb begin
    next_ap_valid            = ap_take;
    next_ap_write            = hwrite;
    next_ap_addr             = haddr[7:0];
    next_force_enable        = force_enable;
    next_used_count          = used_count;
    next_forced_group_select = forced_group_select;
    next_remote_sel          = remote_sel;
    next_irq_mask            = irq_mask;
    next_hrdata              = '0;
    next_irq_status          = irq_status;
    if (wr_ctrl) begin
      next_force_enable = hwdata[`SGS_CTRL_FORCE];
      next_used_count   = hwdata[`SGS_CTRL_USED_MSB:`SGS_CTRL_USED_LSB] > MAX_IDX ?
                          MAX_IDX : hwdata[`SGS_CTRL_USED_MSB:`SGS_CTRL_USED_LSB];
    end
    if (wr_force && wsel <= `SGS_SEL_MAX) begin
      next_forced_group_select = wsel;
    end
    if (wr_remote && wsel <= `SGS_SEL_MAX) begin
      next_remote_sel = wsel;
    end
    if (wr_mask) begin
      next_irq_mask = hwdata[3:0];
    end
    if (ap_take && !hwrite) begin
      unique case (haddr[7:0])
        `SGS_OFF_CTRL: begin
          next_hrdata[`SGS_CTRL_FORCE] = force_enable;
          next_hrdata[`SGS_CTRL_USED_MSB:`SGS_CTRL_USED_LSB] = used_count;
        end
        `SGS_OFF_FORCE:    next_hrdata[3:0] = forced_group_select;
        `SGS_OFF_REMOTE:   next_hrdata[3:0] = remote_sel;
        `SGS_OFF_STATUS:   next_hrdata[2:0] = active_group;
        `SGS_OFF_IRQ_STAT: begin
          next_hrdata[3:0] = irq_status;
          next_irq_status  = '0;
        end
        `SGS_OFF_IRQ_MASK: next_hrdata[3:0] = irq_mask;
        default:           next_hrdata      = '0;
      endcase
    end
    // events set after the read clear, so a set in that cycle wins
    if (next_active != active_group) begin
      next_irq_status[`SGS_EV_CHANGE] = 1'b1;
    end
    if (fail_cfg) begin
      next_irq_status[`SGS_EV_NOT_CFG] = 1'b1;
    end
    if (fail_force) begin
      next_irq_status[`SGS_EV_FORCE_FAIL] = 1'b1;
    end
    if (fail_prio) begin
      next_irq_status[`SGS_EV_PRIO_FAIL] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ap_valid            <= 1'b0;
      ap_write            <= 1'b0;
      ap_addr             <= '0;
      force_enable        <= 1'b0;
      used_count          <= `SGS_RST_USED;
      forced_group_select <= `SGS_SEL_NONE;
      remote_sel          <= `SGS_SEL_NONE;
      irq_status          <= '0;
      irq_mask            <= '0;
      irq                 <= 1'b0;
      hrdata              <= '0;
      hreadyout           <= 1'b1;
      hresp               <= 1'b0;
    end else begin
      ap_valid            <= next_ap_valid;
      ap_write            <= next_ap_write;
      ap_addr             <= next_ap_addr;
      force_enable        <= next_force_enable;
      used_count          <= next_used_count;
      forced_group_select <= next_forced_group_select;
      remote_sel          <= next_remote_sel;
      irq_status          <= next_irq_status;
      irq_mask            <= next_irq_mask;
      irq                 <= next_irq;
      hrdata              <= next_hrdata;
      hreadyout           <= 1'b1;
      hresp               <= 1'b0;
    end
  end

  chk_idle_group_one: assert property (@(posedge clk) disable iff (reset)
    (used_count == `SGS_RST_USED) |=> (active_group == `SGS_RST_ACTIVE))
    else $error("idle selector left group one");

  chk_force_ignores: assert property (@(posedge clk) disable iff (reset)
    (force_enable && !ext_req && !wr_ctrl && en[active_group]) |=> $stable(active_group))
    else $error("group changed under force without request");

  chk_prio_pick: assert property (@(posedge clk) disable iff (reset)
    (!force_enable && used_count != 3'h0 && |(group_ctrl & en))
    |=> (active_group == $past(pif.idx)) && !(|(sgs_above(active_group) & $past(group_ctrl) & $past(en))))
    else $error("lowest requested group not selected");

  chk_pulse_latch: assert property (@(posedge clk) disable iff (reset)
    (!force_enable && group_ctrl == 8'h00 && !wr_ctrl && en[active_group]) |=> $stable(active_group))
    else $error("latched group lost without request");

  chk_force_apply: assert property (@(posedge clk) disable iff (reset)
    (force_enable && fwr && en[3'(wsel - 4'h1)]) |=> (active_group == 3'($past(wsel) - 4'h1)))
    else $error("forced group not applied");

  chk_force_gate: assert property (@(posedge clk) disable iff (reset)
    (!force_enable && ext_req)
    |=> request_fail && irq_status[`SGS_EV_FORCE_FAIL] && $stable(force_enable))
    else $error("ungated change not refused");

  chk_remote_block: assert property (@(posedge clk) disable iff (reset)
    (force_enable && ext_remote && en[ext_grp] && |(group_ctrl & sgs_above(ext_grp)))
    |=> $stable(active_group) && request_fail && irq_status[`SGS_EV_PRIO_FAIL])
    else $error("remote passed a held higher group");

  chk_reset_state: assert property (@(posedge clk)
    reset |=> (active_group == `SGS_RST_ACTIVE) && !force_enable && !irq)
    else $error("reset state wrong");

  chk_cfg_fail: assert property (@(posedge clk) disable iff (reset)
    (!force_enable && |(group_ctrl & ~en)) |=> request_fail && irq_status[`SGS_EV_NOT_CFG])
    else $error("disabled group request not flagged");

  chk_level_return: assert property (@(posedge clk) disable iff (reset)
    ($fell(force_enable) && used_count != 3'h0 && pif.hit) |=> (active_group == $past(pif.idx)))
    else $error("levels did not retake selection");
endmodule

`default_nettype wire

// ---- testbench/sgs_src.sv ----
/*
  Far-side model: digital inputs and logic signals as pulses or levels,
  plus the local panel change strobe.
  Assumes the bench drives its inputs just after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none

module sgs_src (
  input  wire logic       clk,
  input  wire logic [7:0] lvl,
  input  wire logic [7:0] pls,
  input  wire logic       loc_go,
  input  wire logic [3:0] loc_grp,
  output logic      [7:0] group_ctrl,
  output logic            local_change_valid,
  output logic      [3:0] local_change_group
);
  logic [3:0] last = 4'h0;
  // both control forms share one line per group
  assign group_ctrl = lvl | pls;
  assign local_change_valid = loc_go;
  // idle panel lines show the inverse of the last value
  assign local_change_group = loc_go ? loc_grp : ~last;
  always @(posedge clk) begin
    if (loc_go) begin
      last <= loc_grp;
    end
  end
endmodule

`default_nettype wire

// ---- testbench/sgs_bench.sv ----
/*
  Self-checking bench of the selector against an integer model.
  Assumes the design files and sgs_src are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgs_cfg.svh"

module setting_group_selector_test;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0]  lvl = 8'h00;
  logic [7:0]  pls = 8'h00;
  logic        loc_go = 1'b0;
  logic [3:0]  loc_grp = 4'h0;
  logic [7:0]  p;
  logic [31:0] rd;
  wire  [7:0]  group_ctrl;
  wire         local_change_valid;
  wire  [3:0]  local_change_group;
  wire  [2:0]  active_group;
  wire         irq;
  wire         request_fail;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          seed = 82;
  int          act = 0;
  int          used = 0;
  int          i;

  sgs_src src_u (.clk(clk), .lvl(lvl), .pls(pls), .loc_go(loc_go), .loc_grp(loc_grp),
    .group_ctrl(group_ctrl), .local_change_valid(local_change_valid),
    .local_change_group(local_change_group));

  sgs_top #(.GROUPS(8)) dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .group_ctrl(group_ctrl), .local_change_valid(local_change_valid),
    .local_change_group(local_change_group), .active_group(active_group), .irq(irq),
    .request_fail(request_fail), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic chk_grp(input string n, input int e, input logic [2:0] s);
    check_count++;
    if (s !== 3'(e)) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", n, e, s);
    end
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk_reg("register", e, rd);
    chk_reg("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    pls <= v;
    @(posedge clk);
    pls <= 8'h00;
    #1;
  endtask

  task automatic loc(input logic [3:0] g);
    @(posedge clk);
    loc_grp <= g;
    loc_go <= 1'b1;
    @(posedge clk);
    loc_go <= 1'b0;
    #1;
  endtask

  // lowest enabled asserted group, or -1
  function automatic int win(input logic [7:0] c);
    win = -1;
    for (int k = 7; k >= 0; k--) begin
      if (c[k] && k <= used) begin
        win = k;
      end
    end
  endfunction

  task automatic step(input logic [7:0] c);
    if (win(c) >= 0) begin
      act = win(c);
    end
    chk_grp("active", act, active_group);
  endtask

  task automatic set_used(input int u, input logic f);
    used = u;
    xfer(1'b1, `SGS_OFF_CTRL, {25'h0, 3'(u), 3'h0, f});
    if (act > used) begin
      act = 0;
    end
    // a shrunk count drops the active group one edge after the write
    @(posedge clk);
    #1;
  endtask

  task automatic chk_fail(input logic e);
    chk_reg("request_fail", {31'h0, e}, {31'h0, request_fail});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk_grp("active", 0, active_group);
    for (i = 0; i < 7; i++) begin
      rdc(8'(i * 4), 32'h0000_0000);
    end
    pulse(8'h04);
    chk_grp("active", 0, active_group);
    chk_fail(1'b1);
    set_used(7, 1'b0);
    rdc(`SGS_OFF_CTRL, 32'h0000_0070);
    pulse(8'h04);
    step(8'h04);
    repeat (3) @(posedge clk);
    #1;
    chk_grp("active", act, active_group);
    pulse(8'h0A);
    step(8'h0A);
    lvl <= 8'h0C;
    repeat (4) @(posedge clk);
    #1;
    step(8'h0C);
    lvl <= 8'h80;
    pulse(8'h10);
    step(8'h90);
    lvl <= 8'h02;
    pulse(8'h10);
    step(8'h12);
    lvl <= 8'h00;
    for (i = 0; i < 24; i++) begin
      p = 8'($random(seed));
      set_used($random(seed) & 7, 1'b0);
      pulse(p);
      step(p);
      chk_fail((p >> (used + 1)) != 8'h00);
    end
    rdc(`SGS_OFF_STATUS, act);
    set_used(7, 1'b0);
    xfer(1'b0, `SGS_OFF_IRQ_STAT, 32'h0000_0000);
    p = 8'h01 << ((act + 1) % 8);
    pulse(p);
    step(p);
    chk_reg("irq", 32'h0, {31'h0, irq});
    xfer(1'b1, `SGS_OFF_IRQ_MASK, 32'h0000_0001);
    chk_reg("irq", 32'h1, {31'h0, irq});
    rdc(`SGS_OFF_IRQ_STAT, 32'h0000_0001);
    chk_reg("irq", 32'h0, {31'h0, irq});
    xfer(1'b1, `SGS_OFF_FORCE, 32'h0000_0003);
    chk_fail(1'b1);
    loc(4'h6);
    chk_grp("active", act, active_group);
    rdc(`SGS_OFF_IRQ_STAT, 32'h0000_0004);
    lvl <= 8'h08;
    repeat (2) @(posedge clk);
    #1;
    step(8'h08);
    set_used(7, 1'b1);
    for (i = 1; i <= 8; i++) begin
      xfer(1'b1, `SGS_OFF_FORCE, i);
      act = i - 1;
      chk_grp("active", act, active_group);
    end
    xfer(1'b0, `SGS_OFF_IRQ_STAT, 32'h0000_0000);
    xfer(1'b1, `SGS_OFF_REMOTE, 32'h0000_0008);
    chk_grp("active", act, active_group);
    rdc(`SGS_OFF_IRQ_STAT, 32'h0000_0008);
    xfer(1'b1, `SGS_OFF_REMOTE, 32'h0000_0002);
    act = 1;
    chk_grp("active", act, active_group);
    loc(4'h6);
    act = 5;
    chk_grp("active", act, active_group);
    set_used(7, 1'b0);
    @(posedge clk);
    #1;
    step(8'h08);
    lvl <= 8'h00;
    set_used(7, 1'b1);
    xfer(1'b1, `SGS_OFF_FORCE, 32'h0000_0006);
    act = 5;
    set_used(7, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk_grp("active", act, active_group);
    set_used(2, 1'b0);
    chk_grp("active", act, active_group);
    xfer(1'b0, `SGS_OFF_IRQ_STAT, 32'h0000_0000);
    pulse(8'h10);
    step(8'h10);
    rdc(`SGS_OFF_IRQ_STAT, 32'h0000_0002);
    results();
  end
endmodule

`default_nettype wire
